// ==== rtl/dnc_pkg.sv ====
package dnc_pkg;
  // register offsets on the configuration port
  localparam logic [7:0] ADDR_TUNE_LO = 8'h0d;
  localparam logic [7:0] ADDR_TUNE_HI = 8'h0e;
  localparam logic [7:0] ADDR_SEL_SRC = 8'h0f;
  localparam logic [7:0] ADDR_SEL_CODE = 8'h10;
  localparam logic [7:0] ADDR_RST_POL = 8'h11;
  localparam logic [7:0] ADDR_GAIN1 = 8'h14;
  localparam logic [7:0] ADDR_GAIN2 = 8'h16;
  localparam logic [7:0] ADDR_WBF_GAIN = 8'h1f;
  // widths and reset values
  localparam int REG_W = 8;
  localparam int FTW_W = 16;
  localparam int SAMP_W = 16;
  localparam int OSC_N = 3;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] CODE_RST = 2'h0;
  localparam logic [15:0] SAMP_ZERO = 16'h0000;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // oscillator choice codes
  localparam logic [1:0] SEL_FIRST = 2'h0;
  localparam logic [1:0] SEL_SECOND = 2'h1;
  localparam logic [1:0] SEL_THIRD = 2'h2;
  localparam logic [2:0] OSC_NONE = 3'h0;
  // frame reset policy field
  typedef enum logic [1:0] {
    POL_EVERY = 2'h0,
    POL_ONCE = 2'h1,
    POL_TWICE = 2'h2,
    POL_NONE = 2'h3
  } dnc_policy_t;
  // pending frame resets that will still reset the converters
  typedef enum logic [1:0] {
    ARM_IDLE = 2'h0,
    ARM_ONE = 2'h1,
    ARM_TWO = 2'h3
  } dnc_arm_t;
endpackage

// ==== rtl/dnc_seq_if.sv ====
interface dnc_seq_if;
  dnc_pkg::dnc_policy_t policy;
  logic frame_reset;
  logic ddc_start;
  logic clk_resync;
  logic ddc_reset;
  modport ctl (output policy, output frame_reset, output ddc_start, output clk_resync,
    input ddc_reset);
  modport seq (input policy, input frame_reset, input ddc_start, input clk_resync,
    output ddc_reset);
endinterface

// ==== rtl/dnc_reset_seq.sv ====
module dnc_reset_seq (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  dnc_seq_if.seq bus_if
);
  dnc_pkg::dnc_arm_t arm_ff;
  dnc_pkg::dnc_arm_t nxt_arm;
  logic rst_ff;
  logic nxt_rst;
  logic quiet;

  // arming: a start or a resync in the same cycle as a frame reset wins
  always_comb
  begin
    nxt_arm = arm_ff;
    case (bus_if.policy)
      dnc_pkg::POL_ONCE, dnc_pkg::POL_TWICE:
      begin
        if (bus_if.frame_reset)
        begin
          case (arm_ff)
            dnc_pkg::ARM_TWO: nxt_arm = dnc_pkg::ARM_ONE; // [RQ7]
            dnc_pkg::ARM_ONE: nxt_arm = dnc_pkg::ARM_IDLE; // [RQ6]
            default: nxt_arm = dnc_pkg::ARM_IDLE;
          endcase
        end
        if (bus_if.ddc_start)
          nxt_arm = dnc_pkg::ARM_ONE; // [RQ6] [RQ7]
        if (bus_if.clk_resync)
          nxt_arm = (bus_if.policy == dnc_pkg::POL_TWICE) ? dnc_pkg::ARM_TWO
                                                          : dnc_pkg::ARM_ONE; // [RQ7]
      end
      default: nxt_arm = dnc_pkg::ARM_IDLE;
    endcase
  end

  // which event fires the converter reset under each policy
  always_comb
  begin
    case (bus_if.policy)
      dnc_pkg::POL_EVERY: nxt_rst = bus_if.frame_reset; // [RQ5]
      dnc_pkg::POL_NONE: nxt_rst = bus_if.ddc_start; // no latency guarantee here [RQ8] [RQ9]
      default: nxt_rst = bus_if.frame_reset && (arm_ff != dnc_pkg::ARM_IDLE); // [RQ6]
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      arm_ff <= dnc_pkg::ARM_IDLE;
    else
      arm_ff <= nxt_arm;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      rst_ff <= 1'b0;
    else
      rst_ff <= nxt_rst;
  end

  assign bus_if.ddc_reset = rst_ff;
  assign quiet = !bus_if.ddc_start && !bus_if.clk_resync;

  chk_every_frame: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [RQ5]
    (bus_if.policy == dnc_pkg::POL_EVERY) && bus_if.frame_reset |=> bus_if.ddc_reset)
    else $error("frame reset did not reset converters");
  chk_ignore_frame: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [RQ8]
    (bus_if.policy == dnc_pkg::POL_NONE) |=> (bus_if.ddc_reset == $past(bus_if.ddc_start)))
    else $error("reset did not follow start alone");
  chk_once_idle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [RQ6]
    (bus_if.policy == dnc_pkg::POL_ONCE) && bus_if.ddc_start ##1
    (bus_if.policy == dnc_pkg::POL_ONCE) && bus_if.frame_reset && quiet ##1
    (bus_if.policy == dnc_pkg::POL_ONCE) && bus_if.frame_reset && quiet
    |=> !bus_if.ddc_reset && $past(bus_if.ddc_reset))
    else $error("single-shot policy reset wrong number of times");
  chk_twice_resync: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [RQ7]
    (bus_if.policy == dnc_pkg::POL_TWICE) && bus_if.clk_resync ##1
    (bus_if.policy == dnc_pkg::POL_TWICE) && bus_if.frame_reset && quiet ##1
    (bus_if.policy == dnc_pkg::POL_TWICE) && bus_if.frame_reset && quiet
    |=> bus_if.ddc_reset && $past(bus_if.ddc_reset))
    else $error("resync did not give two frame resets");
endmodule // dnc_reset_seq

// ==== rtl/dnc_top.sv ====
// Behaviour
// RQ1 - upper byte of band-2 oscillator tuning word held in a read-write register
// RQ2 - band-2 tuning word and output only used when dual-band is on
// RQ3 - oscillator choice from register when source bit 0, from pins when 1
// RQ4 - register code 00, 01, 10 picks first, second, third oscillator
// RQ5 - policy 00 resets every converter on each frame reset
// RQ6 - policy 01 resets on first frame reset after start, then only after resync
// RQ7 - policy 10 like 01 but each resync uses two frame resets
// RQ8 - policy 11 ignores frame resets, resets only on converter start
// RQ9 - policy 11 gives no deterministic output latency
// RQ10 - first converter gain bit doubles its output, else passes unscaled
// RQ11 - per-converter doubling never applies to the high-bandwidth filter path
// RQ12 - second converter has its own doubling gain bit
// RQ13 - lower byte of band-2 tuning word held in a companion register
// RQ14 - separate doubling gain control for the wide-bandwidth filter output
// RQ15 - host writes zero to reserved write-only bits
// RQ16 - host avoids selection code 11
module dnc_top (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic dual_band_i,
  input wire logic hbf_path_i,
  input wire logic [1:0] gpio_sel_i,
  input wire logic frame_reset_i,
  input wire logic ddc_start_i,
  input wire logic clk_resync_i,
  input wire logic [15:0] band1_data_i,
  input wire logic [15:0] band2_data_i,
  output logic [15:0] band1_data_o,
  output logic [15:0] band2_data_o,
  output logic [15:0] band2_ftw_o,
  output logic [2:0] osc_sel_o,
  output logic ddc_reset_o
);
  logic [7:0] tune_lo_ff;
  logic [7:0] tune_hi_ff;
  logic sel_src_ff;
  logic [1:0] sel_code_ff;
  dnc_pkg::dnc_policy_t policy_ff;
  logic gain1_ff;
  logic gain2_ff;
  logic wbf_gain_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic [15:0] band1_ff;
  logic [15:0] band2_ff;
  logic [15:0] ftw_ff;
  logic [2:0] osc_sel_ff;
  logic [1:0] act_code;
  logic eff_gain1;
  logic eff_gain2;

  dnc_seq_if seq_bus ();

  // write strobe for one register offset
  function automatic logic wr_hit(input logic [7:0] addr);
    wr_hit = reg_wr_i && (reg_addr_i == addr);
  endfunction

  // doubling saturates instead of wrapping so a full-scale tone stays sane
  function automatic logic [15:0] dbl_sat(input logic [15:0] x, input logic en);
    if (!en)
      dbl_sat = x;
    else if (x[15] != x[14])
      dbl_sat = x[15] ? 16'h8000 : 16'h7fff;
    else
      dbl_sat = {x[14:0], 1'b0};
  endfunction

  // code 11 selects no oscillator at all
  function automatic logic [2:0] osc_onehot(input logic [1:0] code);
    case (code)
      dnc_pkg::SEL_FIRST: osc_onehot = 3'h1;
      dnc_pkg::SEL_SECOND: osc_onehot = 3'h2;
      dnc_pkg::SEL_THIRD: osc_onehot = 3'h4;
      default: osc_onehot = dnc_pkg::OSC_NONE;
    endcase
  endfunction

  // band-2 tuning word bytes
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      tune_lo_ff <= dnc_pkg::REG_RST;
      tune_hi_ff <= dnc_pkg::REG_RST;
    end
    else
    begin
      if (wr_hit(dnc_pkg::ADDR_TUNE_LO))
        tune_lo_ff <= reg_wdata_i; // [RQ13]
      if (wr_hit(dnc_pkg::ADDR_TUNE_HI))
        tune_hi_ff <= reg_wdata_i; // [RQ1]
    end
  end

  // oscillator selection source and code; reserved bits are not stored
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      sel_src_ff <= 1'b0;
      sel_code_ff <= dnc_pkg::CODE_RST;
    end
    else
    begin
      if (wr_hit(dnc_pkg::ADDR_SEL_SRC))
        sel_src_ff <= reg_wdata_i[0];
      if (wr_hit(dnc_pkg::ADDR_SEL_CODE))
        sel_code_ff <= reg_wdata_i[1:0];
    end
  end

  // frame reset policy
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      policy_ff <= dnc_pkg::POL_EVERY;
    else if (wr_hit(dnc_pkg::ADDR_RST_POL))
      policy_ff <= dnc_pkg::dnc_policy_t'(reg_wdata_i[1:0]);
  end

  // doubling gain bits
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      gain1_ff <= 1'b0;
      gain2_ff <= 1'b0;
      wbf_gain_ff <= 1'b0;
    end
    else
    begin
      if (wr_hit(dnc_pkg::ADDR_GAIN1))
        gain1_ff <= reg_wdata_i[0]; // [RQ10]
      if (wr_hit(dnc_pkg::ADDR_GAIN2))
        gain2_ff <= reg_wdata_i[0]; // [RQ12]
      if (wr_hit(dnc_pkg::ADDR_WBF_GAIN))
        wbf_gain_ff <= reg_wdata_i[0]; // [RQ14]
    end
  end

  // readback one cycle after the strobe; write-only bits read as zero
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      rdata_ff <= dnc_pkg::RD_UNMAPPED;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_rd_i;
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          dnc_pkg::ADDR_TUNE_LO: rdata_ff <= tune_lo_ff;
          dnc_pkg::ADDR_TUNE_HI: rdata_ff <= tune_hi_ff; // [RQ1]
          dnc_pkg::ADDR_SEL_SRC: rdata_ff <= {7'h00, sel_src_ff};
          dnc_pkg::ADDR_SEL_CODE: rdata_ff <= {6'h00, sel_code_ff};
          dnc_pkg::ADDR_RST_POL: rdata_ff <= {6'h00, policy_ff};
          dnc_pkg::ADDR_GAIN1: rdata_ff <= {7'h00, gain1_ff};
          dnc_pkg::ADDR_GAIN2: rdata_ff <= {7'h00, gain2_ff};
          dnc_pkg::ADDR_WBF_GAIN: rdata_ff <= {7'h00, wbf_gain_ff};
          default: rdata_ff <= dnc_pkg::RD_UNMAPPED;
        endcase
      end
    end
  end

  // pin path is taken straight, so pins must be stable around the switch
  assign act_code = sel_src_ff ? gpio_sel_i : sel_code_ff; // [RQ3]

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      osc_sel_ff <= dnc_pkg::OSC_NONE;
    else
      osc_sel_ff <= osc_onehot(act_code); // [RQ4]
  end

  // high-bandwidth path takes only the wide-filter gain
  assign eff_gain1 = hbf_path_i ? wbf_gain_ff : gain1_ff; // [RQ11] [RQ14]
  assign eff_gain2 = hbf_path_i ? wbf_gain_ff : gain2_ff; // [RQ11]

  // scaled outputs and band-2 tuning word
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      band1_ff <= dnc_pkg::SAMP_ZERO;
      band2_ff <= dnc_pkg::SAMP_ZERO;
      ftw_ff <= dnc_pkg::SAMP_ZERO;
    end
    else
    begin
      band1_ff <= dbl_sat(band1_data_i, eff_gain1); // [RQ10]
      band2_ff <= dual_band_i ? dbl_sat(band2_data_i, eff_gain2) : dnc_pkg::SAMP_ZERO; // [RQ12]
      ftw_ff <= dual_band_i ? {tune_hi_ff, tune_lo_ff} : dnc_pkg::SAMP_ZERO; // [RQ2] [RQ13]
    end
  end

  assign seq_bus.policy = policy_ff;
  assign seq_bus.frame_reset = frame_reset_i;
  assign seq_bus.ddc_start = ddc_start_i;
  assign seq_bus.clk_resync = clk_resync_i;

  dnc_reset_seq u_seq (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .bus_if(seq_bus.seq)
  );

  assign ddc_reset_o = seq_bus.ddc_reset;
  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign band1_data_o = band1_ff;
  assign band2_data_o = band2_ff;
  assign band2_ftw_o = ftw_ff;
  assign osc_sel_o = osc_sel_ff;

  chk_tune_word: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [RQ1]
    reg_wr_i && (reg_addr_i == dnc_pkg::ADDR_TUNE_HI) ##1 dual_band_i && !reg_wr_i
    |=> band2_ftw_o[15:8] == $past(reg_wdata_i, 2))
    else $error("upper tuning byte not on band-2 word");
  chk_band2_off: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [RQ2]
    !dual_band_i |=> (band2_ftw_o == 16'h0000) && (band2_data_o == 16'h0000))
    else $error("band-2 active while dual-band is off");
  chk_sel_pins: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [RQ3]
    sel_src_ff && (gpio_sel_i == 2'h1) |=> osc_sel_o == 3'h2)
    else $error("pin selection not followed");
  chk_sel_reg: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [RQ4]
    !sel_src_ff && (sel_code_ff == 2'h2) |=> osc_sel_o == 3'h4)
    else $error("register code 10 did not pick third oscillator");
  chk_gain_one: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [RQ10]
    !hbf_path_i && gain1_ff && (band1_data_i[15:14] == 2'h0)
    |=> band1_data_o == {$past(band1_data_i[14:0]), 1'b0})
    else $error("first converter not doubled");
  chk_hbf_gain: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [RQ11]
    hbf_path_i && !wbf_gain_ff |=> band1_data_o == $past(band1_data_i))
    else $error("per-converter gain leaked into wide path");
  chk_gain_two: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [RQ12]
    dual_band_i && !hbf_path_i && gain2_ff && (band2_data_i == 16'h7000)
    |=> band2_data_o == 16'h7fff)
    else $error("second converter doubling wrong");
endmodule // dnc_top

// ==== bench/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic dual_band_i, hbf_path_i, frame_reset_i, ddc_start_i, clk_resync_i, ddc_reset_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [1:0] gpio_sel_i;
  logic [2:0] osc_sel_o;
  logic [15:0] band1_data_i, band2_data_i, band1_data_o, band2_data_o, band2_ftw_o;
  int bad_count = 0;
  int num_checks = 0;
  // address, written value, value read back with reserved bits dropped
  logic [7:0] addr_tab [9] = '{dnc_pkg::ADDR_TUNE_HI, dnc_pkg::ADDR_TUNE_LO,
    dnc_pkg::ADDR_SEL_SRC, dnc_pkg::ADDR_SEL_CODE, dnc_pkg::ADDR_RST_POL,
    dnc_pkg::ADDR_GAIN1, dnc_pkg::ADDR_GAIN2, dnc_pkg::ADDR_WBF_GAIN, 8'h20};
  // reserved bits stay zero on every write; only the unmapped offset gets ones
  logic [7:0] wr_tab [9] = '{8'ha5, 8'h3c, 8'h01, 8'h02, 8'h03, 8'h01, 8'h01, 8'h01, 8'hff};
  logic [7:0] rb_tab [9] = '{8'ha5, 8'h3c, 8'h01, 8'h02, 8'h03, 8'h01, 8'h01, 8'h01, 8'h00};

  dnc_top dut_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .dual_band_i(dual_band_i),
    .hbf_path_i(hbf_path_i), .gpio_sel_i(gpio_sel_i), .frame_reset_i(frame_reset_i),
    .ddc_start_i(ddc_start_i), .clk_resync_i(clk_resync_i), .band1_data_i(band1_data_i),
    .band2_data_i(band2_data_i), .band1_data_o(band1_data_o), .band2_data_o(band2_data_o),
    .band2_ftw_o(band2_ftw_o), .osc_sel_o(osc_sel_o), .ddc_reset_o(ddc_reset_o));

  // free-running 100 MHz clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // strobe held one full cycle so the edge that takes it sees it settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(16'(reg_rvalid_o), 16'h0001);
    chk(16'(reg_rdata_o), 16'(exp));
  endtask

  task automatic dp(input logic [15:0] b1, b2, e1, e2);
    @(posedge core_clk_i);
    band1_data_i <= b1;
    band2_data_i <= b2;
    @(posedge core_clk_i);
    #1;
    chk(band1_data_o, e1);
    chk(band2_data_o, e2);
  endtask

  // one sequencer event; reset output judged one cycle later when asked
  task automatic ev(input logic f, s, r, en, exp);
    @(posedge core_clk_i);
    frame_reset_i <= f;
    ddc_start_i <= s;
    clk_resync_i <= r;
    @(posedge core_clk_i);
    frame_reset_i <= 1'b0;
    ddc_start_i <= 1'b0;
    clk_resync_i <= 1'b0;
    #1;
    if (en)
      chk(16'(ddc_reset_o), 16'(exp));
  endtask

  task automatic t_regs();
    for (int i = 0; i < 9; i++)
      rd(addr_tab[i], 8'h00);
    for (int i = 0; i < 9; i++)
      wr(addr_tab[i], wr_tab[i]);
    for (int i = 0; i < 9; i++)
      rd(addr_tab[i], rb_tab[i]);
    for (int i = 0; i < 9; i++)
      wr(addr_tab[i], 8'h00);
  endtask

  task automatic t_ftw();
    @(posedge core_clk_i);
    dual_band_i <= 1'b1;
    wr(dnc_pkg::ADDR_TUNE_HI, 8'h5a);
    wr(dnc_pkg::ADDR_TUNE_LO, 8'hc3);
    @(posedge core_clk_i);
    #1;
    chk(band2_ftw_o, 16'h5ac3);
    @(posedge core_clk_i);
    dual_band_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk(band2_ftw_o, 16'h0000);
  endtask

  task automatic t_osc();
    logic [2:0] hot [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    for (int c = 0; c < 4; c++)
    begin
      // code 11 kept off the register field; the pin loop still covers it
      wr(dnc_pkg::ADDR_SEL_CODE, 8'(c % 3));
      @(posedge core_clk_i);
      #1;
      chk(16'(osc_sel_o), 16'(hot[c % 3]));
    end
    wr(dnc_pkg::ADDR_SEL_SRC, 8'h01);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge core_clk_i);
      gpio_sel_i <= 2'(c);
      @(posedge core_clk_i);
      #1;
      chk(16'(osc_sel_o), 16'(hot[c]));
    end
  endtask

  task automatic t_gain();
    @(posedge core_clk_i);
    dual_band_i <= 1'b1;
    dp(16'h1234, 16'h0100, 16'h1234, 16'h0100);
    wr(dnc_pkg::ADDR_GAIN1, 8'h01);
    wr(dnc_pkg::ADDR_GAIN2, 8'h01);
    dp(16'h1000, 16'h0100, 16'h2000, 16'h0200);
    dp(16'h8000, 16'h7000, 16'h8000, 16'h7fff);
    @(posedge core_clk_i);
    hbf_path_i <= 1'b1;
    dp(16'h1000, 16'h0100, 16'h1000, 16'h0100);
    wr(dnc_pkg::ADDR_WBF_GAIN, 8'h01);
    dp(16'h1000, 16'h0100, 16'h2000, 16'h0200);
    @(posedge core_clk_i);
    hbf_path_i <= 1'b0;
    dual_band_i <= 1'b0;
    dp(16'h1000, 16'h0100, 16'h2000, 16'h0000);
  endtask

  // policies walked 00, 01, 10, 11 so each change starts from a known arm state
  task automatic t_policy();
    ev(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    ev(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    wr(dnc_pkg::ADDR_RST_POL, 8'h01);
    ev(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    ev(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    ev(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    ev(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    ev(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    ev(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(dnc_pkg::ADDR_RST_POL, 8'h02);
    ev(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    ev(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    ev(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    ev(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    ev(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    ev(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    ev(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(dnc_pkg::ADDR_RST_POL, 8'h03);
    ev(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    ev(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
  endtask

  // arm, then two frame resets in consecutive cycles; spaced events miss this case
  task automatic t_burst(input logic [7:0] pol, input logic s, r, e2);
    wr(dnc_pkg::ADDR_RST_POL, pol);
    @(posedge core_clk_i);
    ddc_start_i <= s;
    clk_resync_i <= r;
    @(posedge core_clk_i);
    ddc_start_i <= 1'b0;
    clk_resync_i <= 1'b0;
    frame_reset_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    chk(16'(ddc_reset_o), 16'h0001);
    @(posedge core_clk_i);
    frame_reset_i <= 1'b0;
    #1;
    chk(16'(ddc_reset_o), 16'(e2));
    @(posedge core_clk_i);
    #1;
    chk(16'(ddc_reset_o), 16'h0000);
  endtask

  // hang guard, far beyond the fewer than two hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge core_clk_i);
    bad_count++;
    tally_and_finish();
  end

  // main sequence: all inputs defined at time zero, reset for 8 cycles
  initial
  begin
    {sys_rst_i, reg_wr_i, reg_rd_i, dual_band_i, hbf_path_i} = 5'h10;
    {frame_reset_i, ddc_start_i, clk_resync_i} = 3'h0;
    {reg_addr_i, reg_wdata_i, gpio_sel_i} = 18'h00000;
    {band1_data_i, band2_data_i} = 32'h00000000;
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_ftw();
    t_osc();
    t_gain();
    t_policy();
    t_burst(8'h01, 1'b1, 1'b0, 1'b0);
    t_burst(8'h02, 1'b0, 1'b1, 1'b1);
    tally_and_finish();
  end
endmodule // tb_top
